// ### inc/dsc_pkg.sv
// Constants and types for the serial command and update block of the DAC
// Operation
// RULE1: Load pin low during shifting: output updates at frame select rising edge.
// RULE2: Load pin high during shifting: update on load falling edge after frame end.
// RULE3: Hardware reset pin or software full reset restores the power-on state.
// RULE4: Clear pin falling edge forces output to code chosen by control bits 10:9.
// RULE5: After clear, output keeps clear value until the DAC register is reloaded.
// RULE6: Alert goes low on faults; bit 12 short circuit, bit 11 brownout, else thermal.
// RULE7: Alert held low after power-up and resets until first control write.
// RULE8: Overtemperature pulls alert low; shutdown enable set powers the logic down.
// RULE9: 24-bit input shift register, loaded MSB first on the serial clock.
// RULE10: Word: three ignored bits, bit 20 zero, command 19:16, data 15:0.
// RULE11: Twelve-bit variant takes data from bits 15:4, ignores bits 3:0.
// RULE12: Commands 0000 nop, 0001 write input, 0010 update, 0011 write and update.
// RULE13: 0100 writes control, 0111 data reset, 1000 reserved, 1001 daisy off.
// RULE14: 1010/1011/1100 arm readback; 1111 full reset; 0101 0110 1101 1110 nop.
// RULE15: After resets output clamped and buffer off until a control write.
// RULE16: Host sends full reset before writing a new output range.
// RULE17: Sample on serial clock falling edges; exactly 24 edges or word invalid.
// RULE18: Readback shifts out next 24-clock frame; output tristate while frame high.
// RULE19: Reserved and nop codes change nothing except shifting pending readback.
package dsc_pkg;

   localparam int FRAME_BITS = 24;
   localparam logic [4:0] FRAME_BITS_W = 5'h18;
   localparam logic TWELVE_BIT = 1'b0;
   localparam logic [15:0] DATA_MASK_12 = 16'hFFF0;

   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WR_INPUT = 4'h1;
   localparam logic [3:0] CMD_UPDATE = 4'h2;
   localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
   localparam logic [3:0] CMD_WR_CTRL = 4'h4;
   localparam logic [3:0] CMD_DATA_RESET = 4'h7;
   localparam logic [3:0] CMD_DAISY_OFF = 4'h9;
   localparam logic [3:0] CMD_RB_INPUT = 4'hA;
   localparam logic [3:0] CMD_RB_DAC = 4'hB;
   localparam logic [3:0] CMD_RB_CTRL = 4'hC;
   localparam logic [3:0] CMD_FULL_RESET = 4'hF;

   localparam int WORD_ZERO_BIT = 20;
   localparam int CTRL_WIDTH = 11;
   localparam int CTRL_CV_HI = 10;
   localparam int CTRL_CV_LO = 9;
   localparam int CTRL_ETS_BIT = 6;
   localparam logic [10:0] CTRL_RESET = 11'h000;

   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hFFFF;
   localparam logic [15:0] DAC_RESET = 16'h0000;

   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
   localparam logic [7:0] ADDR_CTRL_VIEW = 8'h08;
   localparam logic [7:0] ADDR_DATA_VIEW = 8'h0C;
   localparam logic [7:0] ADDR_STATE_VIEW = 8'h10;

   localparam int IRQ_W = 4;
   localparam int IRQ_FRAME = 0;
   localparam int IRQ_BAD_FRAME = 1;
   localparam int IRQ_FAULT = 2;
   localparam int IRQ_CLEAR = 3;
   localparam logic [3:0] IRQ_RESET = 4'h0;

   typedef enum logic [1:0] {
      RB_NONE = 2'b00,
      RB_INPUT = 2'b01,
      RB_DAC = 2'b10,
      RB_CTRL = 2'b11
   } dsc_rb_t;

   typedef struct packed {
      logic frameSelN;
      logic serClk;
      logic serDataIn;
      logic load_output_n;
      logic clearN;
      logic hwResetN;
   } dsc_pins_t;

   typedef struct packed {
      logic shortCircuit;
      logic brownout;
      logic overTemp;
   } dsc_fault_t;

endpackage

// ### verilog/dsc_top.sv
// Serial command decoder, update control, clear, reset and alert of the DAC
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module dsc_top
   import dsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire dsc_pkg::dsc_pins_t pins,
   input wire dsc_pkg::dsc_fault_t faults,
   output logic serDataOut,
   output logic serDataOutEn,
   output logic alertN,
   output logic [15:0] dacCode,
   output logic outputClamp,
   output logic bufferPowerUp,
   output logic digitalPowerDown,
   output logic irq,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import dsc_pkg::*;

   function automatic logic [15:0] dataField(input logic [15:0] raw);
      dataField = TWELVE_BIT ? (raw & DATA_MASK_12) : raw; // [RULE11]
   endfunction

   function automatic logic [15:0] clearCode(input logic [1:0] sel);
      clearCode = (sel == 2'b00) ? CODE_ZERO :
                  (sel == 2'b01) ? CODE_MID : CODE_FULL;
   endfunction

   // Pins cross into clk by two flops; third stage only for edge finding
   dsc_pins_t pinMeta;
   dsc_pins_t pinSync;
   dsc_pins_t pinPrev;
   dsc_fault_t faultMeta;
   dsc_fault_t faultSync;

   always_ff @(posedge clk)
   begin
      pinMeta <= pins;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
      faultMeta <= faults;
      faultSync <= faultMeta;
   end

   logic frameFall;
   logic frameRise;
   logic sclkFall;
   logic sclkRise;
   logic loadFall;
   logic clearFall;
   assign frameFall = pinPrev.frameSelN & ~pinSync.frameSelN;
   assign frameRise = ~pinPrev.frameSelN & pinSync.frameSelN;
   assign sclkFall = pinPrev.serClk & ~pinSync.serClk;
   assign sclkRise = ~pinPrev.serClk & pinSync.serClk;
   assign loadFall = pinPrev.load_output_n & ~pinSync.load_output_n;
   assign clearFall = pinPrev.clearN & ~pinSync.clearN;

   logic swReset_reg;
   logic hwReset;
   logic fullReset;
   assign hwReset = rst | ~pinSync.hwResetN;
   assign fullReset = hwReset | swReset_reg; // [RULE3]

   logic powerDown_reg;

   // Input shift register and edge counter
   logic [23:0] shiftReg;
   logic [4:0] bitCount;
   logic loadLowSeen;

   always_ff @(posedge clk)
   begin
      if (fullReset)
      begin
         shiftReg <= 24'h000000;
         bitCount <= 5'h00;
      end
      else if (frameFall)
      begin
         bitCount <= 5'h00;
      end
      else if (sclkFall && !pinSync.frameSelN)
      begin
         shiftReg <= {shiftReg[22:0], pinSync.serDataIn}; // [RULE9] [RULE17]
         if (bitCount != 5'h1F)
            bitCount <= bitCount + 5'h01;
      end
   end

   // Mode is the load pin level seen while the frame is still low
   always_ff @(posedge clk)
   begin
      if (fullReset)
         loadLowSeen <= 1'b0;
      else if (!pinSync.frameSelN)
         loadLowSeen <= ~pinSync.load_output_n; // [RULE1] [RULE2]
   end

   logic wordValid;
   logic [3:0] cmd;
   logic [15:0] wordData;
   assign wordValid = (bitCount == FRAME_BITS_W)
                      && !shiftReg[WORD_ZERO_BIT]; // [RULE10] [RULE17]
   assign cmd = shiftReg[19:16]; // [RULE10]
   assign wordData = dataField(shiftReg[15:0]);

   logic accept;
   assign accept = frameRise && wordValid && !powerDown_reg;

   // Data path registers
   logic [15:0] inputReg;
   logic [15:0] dacReg;
   logic [15:0] dacCode_reg;
   logic [10:0] ctrlReg;
   logic clamp_reg;
   logic bufferOn_reg;
   logic startupHold;
   logic daisyEn;
   dsc_rb_t rbSel;

   always_ff @(posedge clk)
   begin
      if (fullReset)
      begin
         inputReg <= DAC_RESET; // [RULE3]
         dacReg <= DAC_RESET;
         dacCode_reg <= DAC_RESET;
         ctrlReg <= CTRL_RESET;
         clamp_reg <= 1'b1; // [RULE15]
         bufferOn_reg <= 1'b0;
         startupHold <= 1'b1; // [RULE7]
         daisyEn <= 1'b1;
      end
      else if (!powerDown_reg)
      begin
         if (accept)
         begin
            unique case (cmd) // [RULE12] [RULE13] [RULE14]
               CMD_WR_INPUT:
               begin
                  inputReg <= wordData;
                  if (loadLowSeen)
                  begin
                     dacReg <= wordData; // [RULE1]
                     dacCode_reg <= wordData;
                  end
               end
               CMD_UPDATE:
               begin
                  dacReg <= inputReg;
                  dacCode_reg <= inputReg;
               end
               CMD_WR_UPDATE:
               begin
                  inputReg <= wordData;
                  dacReg <= wordData;
                  dacCode_reg <= wordData;
               end
               CMD_WR_CTRL:
               begin
                  ctrlReg <= wordData[CTRL_WIDTH-1:0];
                  clamp_reg <= 1'b0; // [RULE15]
                  bufferOn_reg <= 1'b1;
                  startupHold <= 1'b0; // [RULE7]
               end
               CMD_DATA_RESET:
               begin
                  inputReg <= DAC_RESET;
                  dacReg <= DAC_RESET;
                  dacCode_reg <= DAC_RESET;
               end
               CMD_DAISY_OFF:
                  daisyEn <= 1'b0;
               default:
               begin
                  // Nop, reserved and readback codes touch no state [RULE19]
               end
            endcase
         end
         else if (loadFall && pinSync.frameSelN)
         begin
            dacReg <= inputReg; // [RULE2]
            dacCode_reg <= inputReg;
         end
         // Clear last so it wins over a load in the same cycle
         if (clearFall)
            dacCode_reg <= clearCode(ctrlReg[CTRL_CV_HI:CTRL_CV_LO]); // [RULE4]
      end
   end
   // The clear code stays on dacCode_reg until a DAC load rewrites it [RULE5]

   // Readback arming follows the latest frame; a rejected frame disarms it
   always_ff @(posedge clk)
   begin
      if (fullReset)
         rbSel <= RB_NONE;
      else if (frameRise && !powerDown_reg)
      begin
         if (accept && cmd == CMD_RB_INPUT)
            rbSel <= RB_INPUT; // [RULE14]
         else if (accept && cmd == CMD_RB_DAC)
            rbSel <= RB_DAC;
         else if (accept && cmd == CMD_RB_CTRL)
            rbSel <= RB_CTRL;
         else
            rbSel <= RB_NONE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         swReset_reg <= 1'b0;
      else
         swReset_reg <= accept && cmd == CMD_FULL_RESET; // [RULE3] [RULE16]
   end

   // Fault flags and thermal shutdown
   logic scFlag;
   logic boFlag;
   logic faultAny;
   logic faultAnyPrev;
   assign faultAny = faultSync.shortCircuit | faultSync.brownout
                     | faultSync.overTemp;

   always_ff @(posedge clk)
   begin
      if (fullReset)
      begin
         scFlag <= 1'b0;
         boFlag <= 1'b0;
         faultAnyPrev <= 1'b0;
      end
      else
      begin
         scFlag <= scFlag | faultSync.shortCircuit; // [RULE6]
         boFlag <= boFlag | faultSync.brownout;
         faultAnyPrev <= faultAny;
      end
   end

   // Only a hardware reset revives logic whose supply has been cut
   always_ff @(posedge clk)
   begin
      if (hwReset)
         powerDown_reg <= 1'b0;
      else if (faultSync.overTemp && ctrlReg[CTRL_ETS_BIT])
         powerDown_reg <= 1'b1; // [RULE8]
   end

   always_ff @(posedge clk)
   begin
      if (fullReset)
         alertN <= 1'b0; // [RULE7]
      else
         alertN <= ~(startupHold | scFlag | boFlag
                     | faultSync.overTemp); // [RULE6] [RULE8]
   end

   // Readback and daisy-chain output, changed on serial clock rising edges
   logic [23:0] rbShift;
   logic rbActive;
   logic daisyBit;
   logic [23:0] rbWord;

   always_comb
   begin
      unique case (rbSel)
         RB_INPUT: rbWord = {4'h0, CMD_RB_INPUT, inputReg};
         RB_DAC: rbWord = {4'h0, CMD_RB_DAC, dacReg};
         RB_CTRL: rbWord = {4'h0, CMD_RB_CTRL, 3'h0, scFlag, boFlag, ctrlReg};
         RB_NONE: rbWord = 24'h000000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (fullReset)
      begin
         rbShift <= 24'h000000;
         rbActive <= 1'b0;
         daisyBit <= 1'b0;
      end
      else if (frameFall)
      begin
         rbShift <= rbWord; // [RULE18]
         rbActive <= (rbSel != RB_NONE);
      end
      else if (sclkRise && !pinSync.frameSelN && bitCount != 5'h00)
      begin
         rbShift <= {rbShift[22:0], 1'b0};
         daisyBit <= shiftReg[FRAME_BITS-1];
      end
   end

   always_ff @(posedge clk)
   begin
      if (fullReset || powerDown_reg)
      begin
         serDataOut <= 1'b0;
         serDataOutEn <= 1'b0;
      end
      else
      begin
         serDataOut <= rbActive ? rbShift[FRAME_BITS-1] : daisyBit;
         serDataOutEn <= !pinSync.frameSelN
                         && (rbActive || daisyEn); // [RULE18]
      end
   end

   always_ff @(posedge clk)
   begin
      dacCode <= dacCode_reg;
      outputClamp <= clamp_reg;
      bufferPowerUp <= bufferOn_reg & ~powerDown_reg;
      digitalPowerDown <= powerDown_reg;
   end

   // AHB-Lite slave, zero wait states
   logic [IRQ_W-1:0] irqStatus;
   logic [IRQ_W-1:0] irqMask;
   logic [IRQ_W-1:0] irqEvents;
   logic wrPending;
   logic [7:0] wrAddr;
   logic addrPhase;
   assign addrPhase = hsel && htrans[1] && hready;
   assign irqEvents = {clearFall, faultAny & ~faultAnyPrev,
                       frameRise & ~wordValid, accept};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wrPending <= 1'b0;
         wrAddr <= 8'h00;
      end
      else if (hready)
      begin
         wrPending <= addrPhase && hwrite;
         wrAddr <= haddr[7:0];
      end
   end

   // A new event wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irqStatus <= IRQ_RESET;
         irqMask <= IRQ_RESET;
      end
      else
      begin
         if (wrPending && wrAddr == ADDR_IRQ_STATUS)
            irqStatus <= (irqStatus & ~hwdata[IRQ_W-1:0]) | irqEvents;
         else
            irqStatus <= irqStatus | irqEvents;
         if (wrPending && wrAddr == ADDR_IRQ_MASK)
            irqMask <= hwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irqStatus & irqMask);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         hrdata <= 32'h00000000;
      else if (addrPhase && !hwrite)
      begin
         unique case (haddr[7:0])
            ADDR_IRQ_STATUS: hrdata <= {28'h0000000, irqStatus};
            ADDR_IRQ_MASK: hrdata <= {28'h0000000, irqMask};
            ADDR_CTRL_VIEW:
               hrdata <= {19'h00000, scFlag, boFlag, ctrlReg};
            ADDR_DATA_VIEW: hrdata <= {inputReg, dacReg};
            ADDR_STATE_VIEW:
               hrdata <= {24'h000000, clamp_reg, bufferOn_reg,
                          powerDown_reg, alertN, daisyEn, rbActive, rbSel};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

endmodule

// ### tb/dsc_host_model.sv
// Serial host model that frames words into the block
`timescale 1ns/1ps
module dsc_host_model
(
   input wire logic clk,
   input wire logic serDataOut,
   output logic frameSelN,
   output logic serClk,
   output logic serDataIn
);
   initial
   begin
      frameSelN = 1'b1;
      serClk = 1'b1;
      serDataIn = 1'b0;
   end
   // Clock idles high and stands still between frames; 160 ns period
   task automatic send(input logic [23:0] w, input int n,
      output logic [23:0] q);
      q = '0;
      @(posedge clk);
      frameSelN <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         serDataIn <= w[23 - (i % 24)];
         repeat (10) @(posedge clk);
         q = {q[22:0], serDataOut};
         serClk <= 1'b0;
         repeat (10) @(posedge clk);
         serClk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      frameSelN <= 1'b1;
      // Released line shows the inverse, never a stale bit
      serDataIn <= ~serDataIn;
      repeat (8) @(posedge clk);
   endtask
endmodule

// ### tb/dsc_top_monitor.sv
// Port checks of the DAC serial command block
`timescale 1ns/1ps
module dsc_top_monitor
   import dsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire dsc_pkg::dsc_pins_t pins,
   input wire dsc_pkg::dsc_fault_t faults,
   input wire logic serDataOutEn,
   input wire logic alertN,
   input wire logic [15:0] dacCode,
   input wire logic outputClamp,
   input wire logic bufferPowerUp,
   input wire logic hreadyout,
   input wire logic hresp
);
   logic [3:0] quietCnt;
   logic quiet;
   assign quiet = pins.frameSelN & pins.load_output_n & pins.clearN
      & pins.hwResetN & (faults == 3'h0);
   // Counts cycles with no event that may move the code
   always_ff @(posedge clk)
   begin
      if (rst || !quiet)
         quietCnt <= 4'h0;
      else if (quietCnt != 4'hF)
         quietCnt <= quietCnt + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rst_state;
      $fell(rst) |-> !alertN && outputClamp && !bufferPowerUp
         && dacCode == DAC_RESET;
   endproperty
   a_rst_state: assert property (p_rst_state)
      else $error("state after reset wrong");
   property p_ready;
      hreadyout;
   endproperty
   a_ready: assert property (p_ready)
      else $error("hreadyout low");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay)
      else $error("hresp not okay");
   property p_tristate;
      pins.frameSelN [*5] |-> !serDataOutEn;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("serial out driven outside frame");
   property p_clear;
      $fell(pins.clearN) |-> ##[1:8] (dacCode == CODE_ZERO
         || dacCode == CODE_MID || dacCode == CODE_FULL);
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear code not applied");
   property p_hold;
      quietCnt > 4'h8 |-> $stable(dacCode);
   endproperty
   a_hold: assert property (p_hold)
      else $error("code moved with no cause");
   property p_fault;
      (faults != 3'h0) [*5] |-> !alertN;
   endproperty
   a_fault: assert property (p_fault)
      else $error("alert high during fault");
   property p_hwrst;
      !pins.hwResetN [*6] |-> !alertN && outputClamp && !bufferPowerUp;
   endproperty
   a_hwrst: assert property (p_hwrst)
      else $error("reset pin not obeyed");
   c_clear: cover property ($fell(pins.clearN));
   c_alert: cover property ($rose(alertN));
   c_frame: cover property ($rose(pins.frameSelN));
endmodule
bind dsc_top dsc_top_monitor u_dsc_top_monitor
(
   .clk(clk), .rst(rst), .pins(pins), .faults(faults),
   .serDataOutEn(serDataOutEn), .alertN(alertN), .dacCode(dacCode),
   .outputClamp(outputClamp), .bufferPowerUp(bufferPowerUp),
   .hreadyout(hreadyout), .hresp(hresp)
);

// ### tb/tb.sv
// Self-checking bench for the DAC serial command block
`timescale 1ns/1ps
module tb;
   import dsc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic loadN = 1'b1;
   logic clrN = 1'b1;
   logic hwrN = 1'b1;
   logic fs, sck, sdi, sdo, sdoEn, alertN, clamp, bufOn, pwrDn, irq;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, r;
   logic hready, hresp;
   logic [15:0] dacCode;
   logic [23:0] rd;
   dsc_fault_t faults = '0;
   dsc_pins_t pins;
   int n_errors = 0;
   int num_checks = 0;
   assign pins = {fs, sck, sdi, loadN, clrN, hwrN};
   initial forever #4 clk = ~clk;
   dsc_top u_dsc_top(.clk(clk), .rst(rst), .pins(pins),
      .faults(faults), .serDataOut(sdo), .serDataOutEn(sdoEn),
      .alertN(alertN), .dacCode(dacCode), .outputClamp(clamp),
      .bufferPowerUp(bufOn), .digitalPowerDown(pwrDn), .irq(irq),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp));
   dsc_host_model u_dsc_host_model(.clk(clk), .serDataOut(sdo),
      .frameSelN(fs), .serClk(sck), .serDataIn(sdi));
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic sf(input logic [23:0] w, input int n = 24);
      u_dsc_host_model.send(w, n, rd);
   endtask
   task automatic t_ctrl();
      chk({alertN, clamp, bufOn, dacCode}, 19'h20000);
      sf(24'h040200);
      chk({alertN, clamp, bufOn}, 3'b101);
      bus(1'b0, ADDR_CTRL_VIEW, 32'h0);
      chk(r, 32'h200);
   endtask
   task automatic t_update();
      loadN <= 1'b0;
      sf(24'h011234);
      loadN <= 1'b1;
      chk(dacCode, 16'h1234);
      sf(24'h015678);
      chk(dacCode, 16'h1234);
      loadN <= 1'b0;
      waitc(8);
      loadN <= 1'b1;
      chk(dacCode, 16'h5678);
      sf(24'hE39ABC);
      chk(dacCode, 16'h9ABC);
      sf(24'h011111);
      chk(dacCode, 16'h9ABC);
      sf(24'h020000);
      chk(dacCode, 16'h1111);
   endtask
   task automatic t_nops();
      logic [3:0] c[6] = '{4'h0, 4'h5, 4'h6, 4'h8, 4'hD, 4'hE};
      foreach (c[i])
      begin
         sf({4'h0, c[i], 16'h4321});
         chk({alertN, clamp, dacCode}, 18'h21111);
      end
   endtask
   task automatic t_rb();
      sf(24'h0B0000);
      chk(sdoEn, 1'b0);
      sf(24'h0A0000);
      chk(rd[15:0], 16'h1111);
      sf(24'h0C0000);
      chk(rd[15:0], 16'h1111);
      sf(24'h000000);
      chk(rd[15:0], 16'h0200);
   endtask
   task automatic t_bad();
      bus(1'b1, ADDR_IRQ_STATUS, 32'hF);
      sf(24'h032222, 23);
      chk(dacCode, 16'h1111);
      sf(24'h032222, 25);
      chk(dacCode, 16'h1111);
      sf(24'h132222);
      chk(dacCode, 16'h1111);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk(r[1], 1'b1);
   endtask
   task automatic t_clear();
      logic [15:0] ex[4] = '{CODE_ZERO, CODE_MID, CODE_FULL, CODE_FULL};
      for (int i = 0; i < 4; i++)
      begin
         sf({13'h0080, 2'(i), 9'h0});
         sf(24'h031357);
         clrN <= 1'b0;
         waitc(8);
         clrN <= 1'b1;
         chk(dacCode, ex[i]);
      end
      waitc(20);
      chk(dacCode, CODE_FULL);
      sf(24'h032468);
      chk(dacCode, 16'h2468);
      sf(24'h070000);
      chk({alertN, dacCode}, {1'b1, DAC_RESET});
   endtask
   task automatic t_irq();
      bus(1'b1, ADDR_IRQ_MASK, 32'h0);
      bus(1'b1, ADDR_IRQ_STATUS, 32'hF);
      faults.shortCircuit <= 1'b1;
      waitc(8);
      chk({alertN, irq}, 2'b00);
      bus(1'b0, ADDR_CTRL_VIEW, 32'h0);
      chk(r[12:11], 2'b10);
      bus(1'b1, ADDR_IRQ_MASK, 32'h4);
      waitc(2);
      chk(irq, 1'b1);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h4);
      waitc(2);
      chk(irq, 1'b0);
      faults.brownout <= 1'b1;
      bus(1'b0, 8'h40, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, ADDR_CTRL_VIEW, 32'h0);
      chk(r[12:11], 2'b11);
      faults <= '0;
   endtask
   task automatic t_resets();
      sf(24'h090000);
      bus(1'b0, ADDR_STATE_VIEW, 32'h0);
      chk(r[3], 1'b0);
      sf(24'h0F0000);
      chk({alertN, clamp, bufOn, dacCode}, 19'h20000);
      bus(1'b0, ADDR_CTRL_VIEW, 32'h0);
      chk(r, 32'h0);
      sf(24'h040000);
      faults.overTemp <= 1'b1;
      waitc(8);
      chk({alertN, pwrDn}, 2'b00);
      faults <= '0;
      sf(24'h040040);
      faults.overTemp <= 1'b1;
      waitc(8);
      chk({alertN, pwrDn}, 2'b01);
      faults <= '0;
      hwrN <= 1'b0;
      waitc(8);
      hwrN <= 1'b1;
      waitc(6);
      chk({alertN, clamp, bufOn, pwrDn}, 4'b0100);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      waitc(20);
      rst <= 1'b0;
      waitc(4);
      t_ctrl();
      t_update();
      t_nops();
      t_rb();
      t_bad();
      t_clear();
      t_irq();
      t_resets();
      print_verdict();
   end
   // About thirty-five frames of some 500 cycles each, with ample margin
   initial
   begin
      waitc(60000);
      n_errors++;
      print_verdict();
   end
endmodule
